/* trim_lock_alert_logic.sv */
// Trim lock combiner with open-drain lock / SMBus alert output and bus slave
`timescale 1ns/1ps
module trim_lock_alert_logic #(
    parameter int UPDATE_CYC = trim_lock_alert_pkg::UPDATE_CYCLES
) (
    input  wire logic                         clk_sys,
    input  wire logic                         reset,
    input  wire logic                         loop_trim_enable_n,
    input  wire logic [5:0]                   adc_lock_ok,
    input  wire trim_lock_alert_pkg::nv_cfg_s nv_cfg,
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe,
    output logic                              trim_lock_alert_out,
    output logic                              trim_lock_alert_oe
);
    import trim_lock_alert_pkg::*;

    logic [1:0]  en_sync;
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_d, sda_d;
    logic [23:0] upd_cnt;
    logic [5:0]  lock_status;
    logic        combined_q;
    logic        alert_bit;
    logic        alert_active;
    bus_state_e  state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [7:0]  tx;
    logic [7:0]  ptr;
    logic        rw;
    logic        first;
    logic        ara;
    logic        nack;
    logic        host_wr, host_val;
    logic        soft_rst;

    // Edge and condition decode on synchronised bus lines
    wire        scl_s    = scl_sync[1];
    wire        sda_s    = sda_sync[1];
    wire        scl_rise = scl_s & ~scl_d;
    wire        scl_fall = ~scl_s & scl_d;
    wire        bus_start = scl_s & scl_d & sda_d & ~sda_s;
    wire        bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
    wire        byte_done = (bit_cnt == BITS_PER_BYTE);
    wire        own_hit   = (shreg[7:1] == DEV_ADDR);
    wire        ara_hit   = (shreg[7:1] == ARA_ADDR) & shreg[0] & alert_active;
    wire        upd_tick  = (upd_cnt == 24'(UPDATE_CYC - 1));
    wire        trim_on   = ~en_sync[1];
    wire [5:0]  masked    = lock_status | nv_cfg.mask;
    wire        combined  = &masked;
    wire        lock_chg  = combined ^ combined_q;
    wire        alert_evt = nv_cfg.alert_mode & lock_chg & ~alert_bit;
    wire        pin_low   = nv_cfg.alert_mode ? alert_active : combined;
    status_s    status;
    assign status = '{rsvd: 1'b0, alert: alert_bit, lock: lock_status};
    wire [7:0]  rd_data = (ptr == REG_STATUS) ? status : 8'h00;
    wire [7:0]  tx_load = ara ? {DEV_ADDR, 1'b0} : rd_data;

    // Two-stage synchronisers for pins, then one delay for edge detection
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            en_sync  <= 2'b11;
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            en_sync  <= {en_sync[0], loop_trim_enable_n};
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
        end
    end

    // Fixed-length update cycle, lock captured at its end while trim is enabled
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            upd_cnt     <= 24'h000000;
            lock_status <= 6'h00;
        end else if (soft_rst) begin
            upd_cnt     <= 24'h000000;
            lock_status <= 6'h00;
        end else begin
            upd_cnt <= upd_tick ? 24'h000000 : upd_cnt + 24'h000001;
            if (upd_tick && trim_on) begin
                lock_status <= adc_lock_ok | ~nv_cfg.selected;
            end
        end
    end

    // Alert bit and pending alert; a new event wins over a host clear
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            combined_q   <= 1'b0;
            alert_bit    <= ALERT_RESET;
            alert_active <= 1'b0;
        end else if (soft_rst) begin
            combined_q   <= 1'b0;
            alert_bit    <= ALERT_RESET;
            alert_active <= 1'b0;
        end else begin
            combined_q <= combined;
            if (alert_evt) begin
                alert_bit    <= 1'b1;
                alert_active <= 1'b1;
            end else if (host_wr) begin
                alert_bit    <= host_val;
                alert_active <= alert_active & host_val;
            end
        end
    end

    // Open-drain pin follows the selected path one cycle later
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            trim_lock_alert_out <= 1'b0;
            trim_lock_alert_oe  <= 1'b0;
        end else begin
            trim_lock_alert_out <= 1'b0;
            trim_lock_alert_oe  <= pin_low;
        end
    end

    // Serial bus slave: address, pointer, data writes, reads and alert response
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state    <= ST_IDLE;
            bit_cnt  <= 4'h0;
            shreg    <= 8'h00;
            tx       <= 8'h00;
            ptr      <= 8'h00;
            rw       <= 1'b0;
            first    <= 1'b0;
            ara      <= 1'b0;
            nack     <= 1'b0;
            sda_out  <= 1'b0;
            sda_oe   <= 1'b0;
            host_wr  <= 1'b0;
            host_val <= 1'b0;
            soft_rst <= 1'b0;
        end else begin
            host_wr  <= 1'b0;
            soft_rst <= 1'b0;
            sda_out  <= 1'b0;
            if (bus_start) begin
                state   <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe  <= 1'b0;
            end else if (bus_stop) begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    ST_ADDR, ST_WBYTE: begin
                        shreg   <= {shreg[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    ST_RBYTE: bit_cnt <= bit_cnt + 4'h1;
                    ST_RACK:  nack <= sda_s;
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state)
                    ST_ADDR: begin
                        if (byte_done && (own_hit || ara_hit)) begin
                            state   <= ST_AACK;
                            sda_oe  <= 1'b1;
                            rw      <= shreg[0];
                            ara     <= ara_hit & ~own_hit;
                            bit_cnt <= 4'h0;
                        end else if (byte_done) begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_AACK: begin
                        bit_cnt <= 4'h0;
                        if (rw) begin
                            state  <= ST_RBYTE;
                            tx     <= tx_load;
                            sda_oe <= ~tx_load[7];
                        end else begin
                            state  <= ST_WBYTE;
                            first  <= 1'b1;
                            sda_oe <= 1'b0;
                        end
                    end
                    ST_WBYTE: begin
                        if (byte_done) begin
                            state  <= ST_WACK;
                            sda_oe <= 1'b1;
                            if (first) begin
                                ptr <= shreg;
                            end else if (ptr == REG_STATUS) begin
                                host_wr  <= 1'b1;
                                host_val <= shreg[ALERT_BIT];
                            end else if (ptr == REG_RESET) begin
                                soft_rst <= 1'b1;
                            end
                        end
                    end
                    ST_WACK: begin
                        state   <= ST_WBYTE;
                        first   <= 1'b0;
                        bit_cnt <= 4'h0;
                        sda_oe  <= 1'b0;
                    end
                    ST_RBYTE: begin
                        if (byte_done) begin
                            state  <= ST_RACK;
                            sda_oe <= 1'b0;
                        end else begin
                            sda_oe <= ~tx[6];
                            tx     <= {tx[6:0], 1'b0};
                        end
                    end
                    ST_RACK: begin
                        bit_cnt <= 4'h0;
                        if (nack) begin
                            state <= ST_IDLE;
                        end else begin
                            state  <= ST_RBYTE;
                            ara    <= 1'b0;
                            tx     <= rd_data;
                            sda_oe <= ~rd_data[7];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Checks on lock capture, output paths and alert handshake
    a_lock_capture: assert property (@(posedge clk_sys) disable iff (reset)
        upd_tick && trim_on && !soft_rst |=> lock_status == $past(adc_lock_ok | ~nv_cfg.selected))
        else $error("lock status not captured at update end");
    a_direct_drive: assert property (@(posedge clk_sys) disable iff (reset)
        !nv_cfg.alert_mode ##1 !nv_cfg.alert_mode |-> trim_lock_alert_oe == $past(&masked)
            && !trim_lock_alert_out)
        else $error("direct lock pin does not follow masked locks");
    a_alert_order: assert property (@(posedge clk_sys) disable iff (reset)
        alert_evt && !soft_rst |=> alert_bit && alert_active && !$past(alert_active)
            ##1 trim_lock_alert_oe)
        else $error("alert bit and pin order wrong on lock change");
    a_alert_hold: assert property (@(posedge clk_sys) disable iff (reset)
        alert_active && !host_wr && !soft_rst |=> alert_active)
        else $error("pending alert dropped without acknowledge");
    a_release_ack: assert property (@(posedge clk_sys) disable iff (reset)
        nv_cfg.alert_mode && host_wr && !host_val && !alert_evt && !soft_rst
            ##1 !lock_chg && nv_cfg.alert_mode |=> !trim_lock_alert_oe)
        else $error("alert pin not released after acknowledge");
    a_reset_block: assert property (@(posedge clk_sys) disable iff (reset)
        soft_rst |=> alert_bit && !alert_active ##1 !trim_lock_alert_oe || !nv_cfg.alert_mode)
        else $error("software reset did not block alerts");
    a_no_blocked: assert property (@(posedge clk_sys) disable iff (reset)
        alert_bit && !alert_active && !host_wr |=> !alert_active)
        else $error("alert raised while blocked");
    a_bit6_write: assert property (@(posedge clk_sys) disable iff (reset)
        host_wr && !alert_evt && !soft_rst |=> alert_bit == $past(host_val)
            && (lock_status == $past(lock_status) || $past(upd_tick)))
        else $error("status write did not act on bit 6 only");
    a_ara_pending: assert property (@(posedge clk_sys) disable iff (reset)
        scl_fall && !bus_start && !bus_stop && state == ST_ADDR && byte_done && !own_hit
            && !alert_active |=> !sda_oe && state == ST_IDLE)
        else $error("alert response address taken with no alert");
    c_alert_raised: cover property (@(posedge clk_sys) disable iff (reset)
        alert_evt ##2 trim_lock_alert_oe);
    c_ara_answer: cover property (@(posedge clk_sys) disable iff (reset) state == ST_AACK && ara);
    c_soft_reset: cover property (@(posedge clk_sys) disable iff (reset) soft_rst);
    c_ack_release: cover property (@(posedge clk_sys) disable iff (reset)
        alert_active && host_wr && !host_val);
endmodule // trim_lock_alert_logic

/* trim_lock_alert_pkg.sv */
// Constants, types and states shared by the trim lock alert logic
package trim_lock_alert_pkg;
    localparam int          CH_NUM         = 6;
    localparam logic [7:0]  REG_STATUS     = 8'h00;   // trim_lock_status offset
    localparam logic [7:0]  REG_RESET      = 8'h08;   // Software reset offset
    localparam int          ALERT_BIT      = 6;       // alert_pending_bit position
    localparam logic [6:0]  DEV_ADDR       = 7'h2A;   // Own bus address, value arbitrary
    localparam logic [6:0]  ARA_ADDR       = 7'h0C;   // Alert Response Address (18h on wire)
    localparam logic        ALERT_RESET    = 1'b1;    // Alerts suppressed after reset
    localparam logic [5:0]  MASK_DEFAULT   = 6'h00;   // Mask bits default cleared
    localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
    localparam int          CLK_PERIOD_NS  = 100;
    localparam int          UPDATE_TIME_NS = 1000000; // One trim update cycle
    localparam int          UPDATE_CYCLES  = UPDATE_TIME_NS / CLK_PERIOD_NS;

    // Status byte layout
    typedef struct packed {
        logic       rsvd;
        logic       alert;
        logic [5:0] lock;
    } status_s;

    // Nonvolatile configuration
    typedef struct packed {
        logic       alert_mode;
        logic [5:0] mask;
        logic [5:0] selected;
    } nv_cfg_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_AACK  = 3'b010,
        ST_WBYTE = 3'b011,
        ST_WACK  = 3'b100,
        ST_RBYTE = 3'b101,
        ST_RACK  = 3'b110
    } bus_state_e;
endpackage

/* smbus_host_model.sv */
// Behavioural SMBus host that bit-bangs the two-wire bus
`timescale 1ns/1ps
module smbus_host_model #(
    parameter int HALF = 8
) (
    input  wire logic clk_sys,
    input  wire logic dev_sda_oe,
    output logic      scl_line,
    output logic      sda_line
);
    import trim_lock_alert_pkg::*;
    logic scl_low;
    logic sda_low;
    // Open-drain wires with pull-ups
    assign scl_line = ~scl_low;
    assign sda_line = ~(sda_low | dev_sda_oe);
    initial begin
        scl_low = 1'h0;
        sda_low = 1'h0;
    end
    // Data set 2 clocks into the low phase, sampled at end of high phase
    task automatic bit_cyc(input logic drv_low, output logic v);
        repeat (2) @(negedge clk_sys);
        sda_low = drv_low;
        repeat (HALF - 2) @(negedge clk_sys);
        scl_low = 1'h0;
        repeat (HALF) @(negedge clk_sys);
        v = sda_line;
        scl_low = 1'h1;
    endtask
    task automatic start_c();
        repeat (HALF) @(negedge clk_sys);
        sda_low = 1'h1;
        repeat (HALF) @(negedge clk_sys);
        scl_low = 1'h1;
    endtask
    task automatic stop_c();
        repeat (2) @(negedge clk_sys);
        sda_low = 1'h1;
        repeat (HALF) @(negedge clk_sys);
        scl_low = 1'h0;
        repeat (HALF) @(negedge clk_sys);
        sda_low = 1'h0;
        repeat (HALF) @(negedge clk_sys);
    endtask
    // Byte out MSB first, returns acknowledge
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) bit_cyc(~b[i], v);
        bit_cyc(1'h0, v);
        ack = ~v;
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic v;
        for (int i = 7; i >= 0; i--) bit_cyc(1'h0, b[i]);
        bit_cyc(~nack, v);
    endtask
    task automatic reg_write(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start_c();
        wbyte({DEV_ADDR, 1'h0}, a0);
        wbyte(ptr, a1);
        wbyte(d, a2);
        stop_c();
        ok = a0 & a1 & a2;
    endtask
    task automatic reg_read(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
        logic a0, a1;
        start_c();
        wbyte({DEV_ADDR, 1'h0}, a0);
        wbyte(ptr, a1);
        stop_c();
        start_c();
        wbyte({DEV_ADDR, 1'h1}, ok);
        rbyte(1'h1, d);
        stop_c();
        ok = ok & a0 & a1;
    endtask
    // Alert response read; device address follows only on acknowledge
    task automatic ara_read(output logic ack, output logic [7:0] who);
        start_c();
        wbyte({ARA_ADDR, 1'h1}, ack);
        who = 8'hFF;
        if (ack) rbyte(1'h1, who);
        stop_c();
    endtask
endmodule // smbus_host_model

/* tb.sv */
// Self-checking bench for the trim lock alert logic
`timescale 1ns/1ps
module tb;
    import trim_lock_alert_pkg::*;
    localparam int UPD = 20;
    logic       clk_sys, reset, loop_trim_enable_n, scl_line, sda_line;
    logic       sda_out, sda_oe, trim_lock_alert_out, trim_lock_alert_oe, ok;
    logic [5:0] adc_lock_ok;
    nv_cfg_s    nv_cfg;
    logic [7:0] rd;
    logic [31:0] rnd;
    int         n_errors, total_checks, cycles;
    trim_lock_alert_logic #(.UPDATE_CYC(UPD)) dut (
        .clk_sys(clk_sys), .reset(reset), .loop_trim_enable_n(loop_trim_enable_n),
        .adc_lock_ok(adc_lock_ok), .nv_cfg(nv_cfg), .scl_in(scl_line), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .trim_lock_alert_out(trim_lock_alert_out),
        .trim_lock_alert_oe(trim_lock_alert_oe));
    smbus_host_model host (.clk_sys(clk_sys), .dev_sda_oe(sda_oe), .scl_line(scl_line),
        .sda_line(sda_line));
    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] next_rand(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [7:0] exp_stat(input logic al, input nv_cfg_s c,
                                            input logic [5:0] a);
        return {1'h0, al, a | ~c.selected};
    endfunction
    function automatic logic [7:0] exp_pin(input nv_cfg_s c, input logic [5:0] a);
        return {7'h00, &(a | ~c.selected | c.mask)};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_upd(input int n);
        repeat (n * UPD + 8) @(negedge clk_sys);
    endtask
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        n_errors = 0;
        total_checks = 0;
        cycles = 0;
        rnd = 32'h0AF12EAD;
        reset = 1'h1;
        loop_trim_enable_n = 1'h1;
        adc_lock_ok = 6'h00;
        nv_cfg = '0;
        repeat (12) @(negedge clk_sys);
        reset = 1'h0;
        repeat (6) @(negedge clk_sys);
        host.reg_read(REG_STATUS, rd, ok);
        chk(rd, 8'h40);
        chk({7'h00, ok}, 8'h01);
        chk({7'h00, sda_out}, 8'h00);
        chk({7'h00, trim_lock_alert_oe}, 8'h00);
        $display("test reset done");
        // Direct mode: corners first, then random channels, selects and masks
        loop_trim_enable_n = 1'h0;
        for (int i = 0; i < 8; i++) begin
            rnd = next_rand(rnd);
            adc_lock_ok = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : rnd[5:0];
            nv_cfg.selected = (i == 0) ? 6'h00 : (i < 3) ? 6'h3F : rnd[11:6];
            nv_cfg.mask = (i == 2) ? 6'h3F : (i < 2) ? 6'h00 : rnd[17:12] & rnd[23:18];
            wait_upd(2);
            chk({7'h00, trim_lock_alert_oe}, exp_pin(nv_cfg, adc_lock_ok));
            chk({7'h00, trim_lock_alert_out}, 8'h00);
            host.reg_read(REG_STATUS, rd, ok);
            chk(rd, exp_stat(1'h1, nv_cfg, adc_lock_ok));
        end
        host.reg_write(REG_STATUS, 8'hBF, ok);
        chk({7'h00, ok}, 8'h01);
        host.reg_read(REG_STATUS, rd, ok);
        chk(rd, exp_stat(1'h0, nv_cfg, adc_lock_ok));
        loop_trim_enable_n = 1'h1;
        // Let the disable pass the pin synchroniser before inputs move
        repeat (3) @(negedge clk_sys);
        adc_lock_ok = ~adc_lock_ok;
        wait_upd(3);
        host.reg_read(REG_STATUS, rd, ok);
        chk(rd, exp_stat(1'h0, nv_cfg, ~adc_lock_ok));
        host.reg_read(8'h05, rd, ok);
        chk(rd, 8'h00);
        $display("test direct done");
        // Alert mode: suppressed after soft reset, then alert on each change
        adc_lock_ok = 6'h3F;
        nv_cfg = '{alert_mode: 1'h1, mask: 6'h00, selected: 6'h3F};
        host.reg_write(REG_RESET, 8'h5A, ok);
        chk({7'h00, ok}, 8'h01);
        host.reg_read(REG_STATUS, rd, ok);
        chk(rd, 8'h40);
        host.ara_read(ok, rd);
        chk({7'h00, ok}, 8'h00);
        host.reg_write(REG_STATUS, 8'h00, ok);
        loop_trim_enable_n = 1'h0;
        wait_upd(2);
        chk({7'h00, trim_lock_alert_oe}, 8'h01);
        host.reg_read(REG_STATUS, rd, ok);
        chk(rd, 8'h7F);
        host.ara_read(ok, rd);
        chk({7'h00, ok}, 8'h01);
        chk(rd, {DEV_ADDR, 1'h0});
        chk({7'h00, trim_lock_alert_oe}, 8'h01);
        host.reg_write(REG_STATUS, 8'h00, ok);
        chk({7'h00, trim_lock_alert_oe}, 8'h00);
        wait_upd(3);
        chk({7'h00, trim_lock_alert_oe}, 8'h00);
        adc_lock_ok = 6'h37;
        wait_upd(2);
        chk({7'h00, trim_lock_alert_oe}, 8'h01);
        host.reg_read(REG_STATUS, rd, ok);
        chk(rd, 8'h77);
        $display("test alert done");
        // Lock reached while suppressed raises no alert
        adc_lock_ok = 6'h3F;
        host.reg_write(REG_RESET, 8'h00, ok);
        wait_upd(3);
        chk({7'h00, trim_lock_alert_oe}, 8'h00);
        host.reg_read(REG_STATUS, rd, ok);
        chk(rd, 8'h7F);
        $display("test suppress done");
        report_and_stop();
    end
endmodule // tb
